// ==== design/psr_core.sv ====
// program sequencer with output assignment and transfer output
// Contract
// - all outputs stay off for five seconds after power-up
// - twelve output functions exist, heat to converter error
// - control outputs take only heat, cool, alarms 1-3, loop break
// - aux output takes only alarms 1-3, loop break, error flags
// - in heat/cool control, cool must sit on control output 1 or 2
// - transfer source is setpoint, process value, heat or cool MV
// - transfer scaled between lo and hi; hi below lo inverts
// - four patterns of sixteen steps, counts configurable
// - time method: step is setpoint plus duration
// - ramp method: step is setpoint, rise rate and soak time
// - pattern is chosen before the program starts
// - setting picks repeat of one pattern or run all ascending
// - advance ends the current step at once
// - hold freezes step timing and setpoint movement
// - alarms compare with values of the running pattern
// - time signal, end and stage reach outputs only by assignment; the assign check rejects their codes 6-9 on every output
// - time signals are on/off timers started at a chosen step
// - configuration mode resets control and forces outputs off
module psr_core #(
	parameter int POWERUP_CYCLES = psr_pkg::POWERUP_CYC,
	parameter int TICK_CYCLES = psr_pkg::TICK_CYC,
	parameter int NPAT = psr_pkg::MAX_PAT,
	parameter int NSTEP = psr_pkg::MAX_STEP
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WE,
	input wire logic REG_RE,
	output logic [15:0] REG_RDATA,
	input wire logic [15:0] MEASURED_PROCESS_VALUE,
	input wire logic [15:0] HEAT_MV,
	input wire logic [15:0] COOL_MV,
	input wire logic HEAT_CTRL,
	input wire logic COOL_CTRL,
	input wire logic CONTROL_LOOP_BREAK_ALARM,
	input wire logic INPUT_ERR,
	input wire logic ADC_ERR,
	input wire logic EV_RUN,
	input wire logic EV_HOLD,
	input wire logic EV_ADVANCE,
	input wire logic EV_PATTERN_EN,
	input wire logic [1:0] EV_PATTERN,
	output logic CTRL_OUT1,
	output logic CTRL_OUT2,
	output logic AUX_OUT1,
	output logic [15:0] XFER_OUT,
	output logic [15:0] PRESENT_TARGET_SETPOINT,
	output logic PROG_END,
	output logic CONTROL_RESET
);
	// ====================================================================
	// parameter check
	generate
		if (NPAT < 1 || NPAT > psr_pkg::MAX_PAT || NSTEP < 1 ||
			NSTEP > psr_pkg::MAX_STEP || TICK_CYCLES < 1 ||
			POWERUP_CYCLES < 1) begin : g_bad
			$error("psr_core: unsupported parameter value");
		end
	endgenerate
	// ====================================================================
	// registers and memories
	logic [15:0] ctrl_r, ctrl_nxt;
	logic [11:0] assign_r, assign_nxt;
	logic [15:0] steps_r, steps_nxt;
	logic [1:0] npat_r, npat_nxt;
	logic [15:0] ts1_r, ts1_nxt, ts2_r, ts2_nxt, xlo_r, xlo_nxt;
	logic [15:0] xhi_r, xhi_nxt;
	logic reject_r, reject_nxt, adv_wr;
	logic [15:0] rdata_nxt;
	logic [15:0] sp_mem [psr_pkg::MEM_DEPTH];
	logic [15:0] tm_mem [psr_pkg::MEM_DEPTH];
	logic [15:0] sk_mem [psr_pkg::MEM_DEPTH];
	logic [15:0] alm_mem [psr_pkg::ALM_DEPTH];
	logic [3:0] f1, f2, fa;
	logic hc_ok;
	psr_route_if rif ();

	always_comb begin
		ctrl_nxt = ctrl_r;
		assign_nxt = assign_r;
		steps_nxt = steps_r;
		npat_nxt = npat_r;
		ts1_nxt = ts1_r;
		ts2_nxt = ts2_r;
		xlo_nxt = xlo_r;
		xhi_nxt = xhi_r;
		reject_nxt = reject_r;
		adv_wr = 1'b0;
		f1 = REG_WDATA[3:0];
		f2 = REG_WDATA[7:4];
		fa = REG_WDATA[11:8];
		hc_ok = (assign_r[3:0] == psr_pkg::FN_COOL) ||
			(assign_r[7:4] == psr_pkg::FN_COOL);
		if (REG_WE) begin
			case (REG_ADDR)
				psr_pkg::REG_CTRL: begin
					ctrl_nxt = REG_WDATA;
					ctrl_nxt[psr_pkg::CB_ADV] = 1'b0;
					adv_wr = REG_WDATA[psr_pkg::CB_ADV];
					if (REG_WDATA[psr_pkg::CB_HCOOL] && !hc_ok) begin
						ctrl_nxt[psr_pkg::CB_HCOOL] = 1'b0;
						reject_nxt = 1'b1;
					end
				end
				psr_pkg::REG_ASSIGN: begin
					if (f1 <= psr_pkg::FN_LOOPBRK && f2 <= psr_pkg::FN_LOOPBRK
						&& ((fa >= psr_pkg::FN_ALM1 && fa <= psr_pkg::FN_LOOPBRK)
						|| fa == psr_pkg::FN_INERR || fa == psr_pkg::FN_ADERR)
						&& (!ctrl_r[psr_pkg::CB_HCOOL] || f1 == psr_pkg::FN_COOL
						|| f2 == psr_pkg::FN_COOL)) begin
						assign_nxt = REG_WDATA[11:0];
						reject_nxt = 1'b0;
					end else begin
						reject_nxt = 1'b1;
					end
				end
				psr_pkg::REG_STEPS: steps_nxt = REG_WDATA;
				psr_pkg::REG_NPAT: npat_nxt = REG_WDATA[1:0];
				psr_pkg::REG_TSIG1: ts1_nxt = REG_WDATA;
				psr_pkg::REG_TSIG2: ts2_nxt = REG_WDATA;
				psr_pkg::REG_XLO: xlo_nxt = REG_WDATA;
				psr_pkg::REG_XHI: xhi_nxt = REG_WDATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (REG_WE) begin
			unique case (REG_ADDR[7:6])
				psr_pkg::RGN_SP: sp_mem[REG_ADDR[5:0]] <= REG_WDATA;
				psr_pkg::RGN_TIME: tm_mem[REG_ADDR[5:0]] <= REG_WDATA;
				psr_pkg::RGN_SOAK: sk_mem[REG_ADDR[5:0]] <= REG_WDATA;
				default: begin
					if (REG_ADDR[7:4] == psr_pkg::REG_ALM_HI) begin
						alm_mem[REG_ADDR[3:0]] <= REG_WDATA;
					end
				end
			endcase
		end
	end
	// ====================================================================
	// power-up inhibit and time base
	logic [31:0] pwr_cnt_r, pwr_cnt_nxt, tdiv_r, tdiv_nxt;
	logic pwr_ok_r, pwr_ok_nxt, tick_r, tick_nxt;

	always_comb begin
		pwr_cnt_nxt = pwr_cnt_r;
		pwr_ok_nxt = pwr_ok_r;
		if (!pwr_ok_r) begin
			pwr_cnt_nxt = pwr_cnt_r + 32'h1;
			pwr_ok_nxt = (pwr_cnt_r == 32'(POWERUP_CYCLES - 1));
		end
		tick_nxt = (tdiv_r == 32'(TICK_CYCLES - 1));
		tdiv_nxt = tick_nxt ? 32'h0 : tdiv_r + 32'h1;
	end
	// ====================================================================
	// sequencer
	psr_pkg::psr_seq_t st_r, st_nxt;
	logic [1:0] pat_r, pat_nxt, psel;
	logic [3:0] step_r, step_nxt, last_step;
	logic [15:0] sp_r, sp_nxt, tmr_r, tmr_nxt, stmr_r, stmr_nxt, tgt, lim;
	logic stage_r, stage_nxt, enter, run_req, hold_req, adv_req, cfg;
	logic [1:0] lastpat;
	logic [5:0] idx;

	always_comb begin
		st_nxt = st_r;
		pat_nxt = pat_r;
		step_nxt = step_r;
		sp_nxt = sp_r;
		tmr_nxt = tmr_r;
		stmr_nxt = stmr_r;
		stage_nxt = stage_r && !tick_r;
		enter = 1'b0;
		idx = {pat_r, step_r};
		tgt = sp_mem[idx];
		cfg = ctrl_r[psr_pkg::CB_CFG];
		run_req = ctrl_r[psr_pkg::CB_RUN] || EV_RUN;
		hold_req = ctrl_r[psr_pkg::CB_HOLD] || EV_HOLD;
		adv_req = adv_wr || EV_ADVANCE;
		psel = EV_PATTERN_EN ? EV_PATTERN : ctrl_r[psr_pkg::CB_PAT +: 2];
		lastpat = (npat_r > 2'(NPAT - 1)) ? 2'(NPAT - 1) : npat_r;
		last_step = steps_r[pat_r*4 +: 4];
		if (last_step > 4'(NSTEP - 1)) begin
			last_step = 4'(NSTEP - 1);
		end
		lim = ctrl_r[psr_pkg::CB_RAMP] ? sk_mem[{pat_r, step_r}] :
			tm_mem[{pat_r, step_r}];
		if (cfg || !run_req) begin
			st_nxt = psr_pkg::SQ_IDLE;
			step_nxt = 4'h0;
		end else begin
			unique case (st_r)
				psr_pkg::SQ_IDLE: begin
					pat_nxt = (psel > lastpat) ? 2'h0 : psel;
					step_nxt = 4'h0;
					enter = 1'b1;
				end
				psr_pkg::SQ_RAMP, psr_pkg::SQ_SOAK: begin
					if (adv_req || (!hold_req && tick_r &&
						st_r == psr_pkg::SQ_SOAK && tmr_r + 16'h1 >= lim)) begin
						if (step_r != last_step) begin
							step_nxt = step_r + 4'h1;
							enter = 1'b1;
						end else if (ctrl_r[psr_pkg::CB_SEQ +: 2] ==
							psr_pkg::SEQ_REPEAT) begin
							step_nxt = 4'h0;
							enter = 1'b1;
						end else if (ctrl_r[psr_pkg::CB_SEQ +: 2] ==
							psr_pkg::SEQ_RUNALL && pat_r != lastpat) begin
							pat_nxt = pat_r + 2'h1;
							step_nxt = 4'h0;
							enter = 1'b1;
						end else begin
							st_nxt = psr_pkg::SQ_END;
						end
					end else if (!hold_req && tick_r) begin
						stmr_nxt = stmr_r + 16'h1;
						if (st_r == psr_pkg::SQ_SOAK) begin
							tmr_nxt = tmr_r + 16'h1;
						end else if (sp_r == tgt) begin
							st_nxt = psr_pkg::SQ_SOAK;
							tmr_nxt = 16'h0;
						end else if (sp_r < tgt) begin
							sp_nxt = (tgt - sp_r > tm_mem[idx]) ?
								sp_r + tm_mem[idx] : tgt;
						end else begin
							sp_nxt = (sp_r - tgt > tm_mem[idx]) ?
								sp_r - tm_mem[idx] : tgt;
						end
					end
				end
				psr_pkg::SQ_END: ;
			endcase
		end
		if (enter) begin
			tmr_nxt = 16'h0;
			stmr_nxt = 16'h0;
			stage_nxt = 1'b1;
			if (ctrl_r[psr_pkg::CB_RAMP]) begin
				st_nxt = psr_pkg::SQ_RAMP;
			end else begin
				st_nxt = psr_pkg::SQ_SOAK;
				sp_nxt = sp_mem[{pat_nxt, step_nxt}];
			end
		end
	end
	// ====================================================================
	// output functions, routing and read-back
	logic run_act, ts1, ts2, outs_ok;
	logic [2:0] alm;

	always_comb begin
		run_act = (st_r == psr_pkg::SQ_RAMP) || (st_r == psr_pkg::SQ_SOAK);
		ts1 = run_act && step_r == ts1_r[3:0] &&
			stmr_r >= {10'h0, ts1_r[9:4]} && stmr_r < {10'h0, ts1_r[15:10]};
		ts2 = run_act && step_r == ts2_r[3:0] &&
			stmr_r >= {10'h0, ts2_r[9:4]} && stmr_r < {10'h0, ts2_r[15:10]};
		for (int k = 0; k < 3; k++) begin
			alm[k] = run_act &&
				MEASURED_PROCESS_VALUE > alm_mem[{pat_r, 2'(k)}];
		end
		outs_ok = pwr_ok_r && !ctrl_r[psr_pkg::CB_CFG];
		rif.func = {ADC_ERR, INPUT_ERR, stage_r, st_r == psr_pkg::SQ_END,
			ts2, ts1, CONTROL_LOOP_BREAK_ALARM, alm,
			COOL_CTRL && ctrl_r[psr_pkg::CB_HCOOL], HEAT_CTRL};
		rif.sel1 = assign_r[3:0];
		rif.sel2 = assign_r[7:4];
		rif.sela = assign_r[11:8];
		rif.xsrc = ctrl_r[psr_pkg::CB_XSRC +: 2];
		rif.sp = sp_r;
		rif.pv = MEASURED_PROCESS_VALUE;
		rif.hmv = HEAT_MV;
		rif.cmv = COOL_MV;
		rif.xlo = xlo_r;
		rif.xhi = xhi_r;
		rdata_nxt = 16'h0000;
		if (REG_RE) begin
			case (REG_ADDR)
				psr_pkg::REG_CTRL: rdata_nxt = ctrl_r;
				psr_pkg::REG_ASSIGN: rdata_nxt = {4'h0, assign_r};
				psr_pkg::REG_STEPS: rdata_nxt = steps_r;
				psr_pkg::REG_NPAT: rdata_nxt = {14'h0, npat_r};
				psr_pkg::REG_TSIG1: rdata_nxt = ts1_r;
				psr_pkg::REG_TSIG2: rdata_nxt = ts2_r;
				psr_pkg::REG_XLO: rdata_nxt = xlo_r;
				psr_pkg::REG_XHI: rdata_nxt = xhi_r;
				psr_pkg::REG_STATUS: rdata_nxt = {step_r, 2'h0, pat_r,
					outs_ok, reject_r, ts2, ts1, stage_r,
					st_r == psr_pkg::SQ_END, hold_req, run_act};
				psr_pkg::REG_SPNOW: rdata_nxt = sp_r;
				default: begin
					unique case (REG_ADDR[7:6])
						psr_pkg::RGN_SP: rdata_nxt = sp_mem[REG_ADDR[5:0]];
						psr_pkg::RGN_TIME: rdata_nxt = tm_mem[REG_ADDR[5:0]];
						psr_pkg::RGN_SOAK: rdata_nxt = sk_mem[REG_ADDR[5:0]];
						default: begin
							if (REG_ADDR[7:4] == psr_pkg::REG_ALM_HI) begin
								rdata_nxt = alm_mem[REG_ADDR[3:0]];
							end
						end
					endcase
				end
			endcase
		end
	end

	psr_out_route u_route (
		.rif(rif.route)
	);
	// ====================================================================
	// state registers
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctrl_r <= psr_pkg::CTRL_RST;
			assign_r <= psr_pkg::ASSIGN_RST;
			steps_r <= psr_pkg::STEPS_RST;
			npat_r <= 2'h0;
			ts1_r <= 16'h0000;
			ts2_r <= 16'h0000;
			xlo_r <= 16'h0000;
			xhi_r <= 16'hFFFF;
			reject_r <= 1'b0;
			pwr_cnt_r <= 32'h0;
			pwr_ok_r <= 1'b0;
			tdiv_r <= 32'h0;
			tick_r <= 1'b0;
			st_r <= psr_pkg::SQ_IDLE;
			pat_r <= 2'h0;
			step_r <= 4'h0;
			sp_r <= 16'h0000;
			tmr_r <= 16'h0000;
			stmr_r <= 16'h0000;
			stage_r <= 1'b0;
			REG_RDATA <= 16'h0000;
			CTRL_OUT1 <= 1'b0;
			CTRL_OUT2 <= 1'b0;
			AUX_OUT1 <= 1'b0;
			XFER_OUT <= 16'h0000;
			PRESENT_TARGET_SETPOINT <= 16'h0000;
			PROG_END <= 1'b0;
			CONTROL_RESET <= 1'b1;
		end else begin
			ctrl_r <= ctrl_nxt;
			assign_r <= assign_nxt;
			steps_r <= steps_nxt;
			npat_r <= npat_nxt;
			ts1_r <= ts1_nxt;
			ts2_r <= ts2_nxt;
			xlo_r <= xlo_nxt;
			xhi_r <= xhi_nxt;
			reject_r <= reject_nxt;
			pwr_cnt_r <= pwr_cnt_nxt;
			pwr_ok_r <= pwr_ok_nxt;
			tdiv_r <= tdiv_nxt;
			tick_r <= tick_nxt;
			st_r <= st_nxt;
			pat_r <= pat_nxt;
			step_r <= step_nxt;
			sp_r <= sp_nxt;
			tmr_r <= tmr_nxt;
			stmr_r <= stmr_nxt;
			stage_r <= stage_nxt;
			REG_RDATA <= rdata_nxt;
			CTRL_OUT1 <= outs_ok && rif.o1;
			CTRL_OUT2 <= outs_ok && rif.o2;
			AUX_OUT1 <= outs_ok && rif.oa;
			XFER_OUT <= outs_ok ? rif.xout : 16'h0000;
			PRESENT_TARGET_SETPOINT <= sp_r;
			PROG_END <= st_r == psr_pkg::SQ_END;
			CONTROL_RESET <= !outs_ok;
		end
	end
endmodule : psr_core

// ==== pkg/psr_pkg.sv ====
// constants, register map and encodings of the program sequencer
package psr_pkg;
	// ====================================================================
	// clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int POWERUP_TIME_S = 5;
	localparam int POWERUP_CYC = POWERUP_TIME_S * CLK_HZ;
	localparam int TICK_TIME_MS = 1000;
	localparam int TICK_CYC = (TICK_TIME_MS * (CLK_HZ / 1000));
	// ====================================================================
	// sizes
	localparam int MAX_PAT = 4;
	localparam int MAX_STEP = 16;
	localparam int MEM_DEPTH = MAX_PAT * MAX_STEP;
	localparam int ALM_DEPTH = 16;
	// ====================================================================
	// register offsets (word index on the register port)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ASSIGN = 8'h01;
	localparam logic [7:0] REG_STEPS = 8'h02;
	localparam logic [7:0] REG_NPAT = 8'h03;
	localparam logic [7:0] REG_TSIG1 = 8'h04;
	localparam logic [7:0] REG_TSIG2 = 8'h05;
	localparam logic [7:0] REG_XLO = 8'h06;
	localparam logic [7:0] REG_XHI = 8'h07;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_SPNOW = 8'h09;
	localparam logic [3:0] REG_ALM_HI = 4'h1;
	localparam logic [1:0] RGN_SP = 2'h1;
	localparam logic [1:0] RGN_TIME = 2'h2;
	localparam logic [1:0] RGN_SOAK = 2'h3;
	// ====================================================================
	// control register fields
	localparam int CB_RUN = 0;
	localparam int CB_HOLD = 1;
	localparam int CB_ADV = 2;
	localparam int CB_CFG = 3;
	localparam int CB_SEQ = 4;
	localparam int CB_RAMP = 6;
	localparam int CB_PAT = 7;
	localparam int CB_HCOOL = 9;
	localparam int CB_XSRC = 10;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [11:0] ASSIGN_RST = 12'h320;
	localparam logic [15:0] STEPS_RST = 16'h0000;
	localparam logic [1:0] SEQ_SINGLE = 2'h0;
	localparam logic [1:0] SEQ_REPEAT = 2'h1;
	localparam logic [1:0] SEQ_RUNALL = 2'h2;
	// ====================================================================
	// output function codes
	localparam logic [3:0] FN_HEAT = 4'h0;
	localparam logic [3:0] FN_COOL = 4'h1;
	localparam logic [3:0] FN_ALM1 = 4'h2;
	localparam logic [3:0] FN_ALM3 = 4'h4;
	localparam logic [3:0] FN_LOOPBRK = 4'h5;
	localparam logic [3:0] FN_INERR = 4'hA;
	localparam logic [3:0] FN_ADERR = 4'hB;
	localparam int FN_COUNT = 12;
	// transfer sources
	localparam logic [1:0] XS_SP = 2'h0;
	localparam logic [1:0] XS_PV = 2'h1;
	localparam logic [1:0] XS_HMV = 2'h2;
	localparam logic [1:0] XS_CMV = 2'h3;
	typedef enum logic [1:0] {SQ_IDLE, SQ_RAMP, SQ_SOAK, SQ_END} psr_seq_t;
endpackage : psr_pkg

// ==== pkg/psr_route_if.sv ====
// routing and transfer bundle between sequencer core and output router
interface psr_route_if;
	logic [psr_pkg::FN_COUNT-1:0] func;
	logic [3:0] sel1;
	logic [3:0] sel2;
	logic [3:0] sela;
	logic [1:0] xsrc;
	logic [15:0] sp;
	logic [15:0] pv;
	logic [15:0] hmv;
	logic [15:0] cmv;
	logic [15:0] xlo;
	logic [15:0] xhi;
	logic o1;
	logic o2;
	logic oa;
	logic [15:0] xout;
	modport core (output func, sel1, sel2, sela, xsrc, sp, pv, hmv, cmv,
		xlo, xhi, input o1, o2, oa, xout);
	modport route (input func, sel1, sel2, sela, xsrc, sp, pv, hmv, cmv,
		xlo, xhi, output o1, o2, oa, xout);
endinterface : psr_route_if

// ==== design/psr_out_route.sv ====
// output function routing and transfer output scaling
module psr_out_route (
	psr_route_if.route rif
);
	logic [15:0] src;
	logic signed [16:0] span;
	logic signed [33:0] prod;
	logic signed [17:0] sum;
	// ====================================================================
	// routing: one function per physical output
	always_comb begin
		rif.o1 = rif.func[rif.sel1];
		rif.o2 = rif.func[rif.sel2];
		rif.oa = rif.func[rif.sela];
	end
	// ====================================================================
	// transfer: lo + (hi - lo) * src / 65536, hi below lo inverts
	always_comb begin
		unique case (rif.xsrc)
			psr_pkg::XS_SP: src = rif.sp;
			psr_pkg::XS_PV: src = rif.pv;
			psr_pkg::XS_HMV: src = rif.hmv;
			psr_pkg::XS_CMV: src = rif.cmv;
		endcase
		span = $signed({1'b0, rif.xhi}) - $signed({1'b0, rif.xlo});
		prod = span * $signed({1'b0, src});
		sum = $signed({2'b00, rif.xlo}) + prod[33:16];
		rif.xout = sum[15:0];
	end
endmodule : psr_out_route

// ==== sim/psr_core_assertions.sv ====
// port-level property checks for the program sequencer
module psr_core_assertions #(
	parameter int POWERUP_CYCLES = 20
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WE,
	input wire logic REG_RE,
	input wire logic [15:0] REG_RDATA,
	input wire logic EV_RUN,
	input wire logic EV_HOLD,
	input wire logic CTRL_OUT1,
	input wire logic CTRL_OUT2,
	input wire logic AUX_OUT1,
	input wire logic [15:0] XFER_OUT,
	input wire logic [15:0] PRESENT_TARGET_SETPOINT,
	input wire logic PROG_END,
	input wire logic CONTROL_RESET
);
	// ==========
	// helper state
	int cnt_r;
	logic cfg_r;
	logic quiet;
	assign quiet = !CTRL_OUT1 && !CTRL_OUT2 && !AUX_OUT1
		&& XFER_OUT == 16'h0000;
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cnt_r <= 0;
			cfg_r <= 1'b0;
		end else begin
			if (cnt_r < POWERUP_CYCLES + 4)
				cnt_r <= cnt_r + 1;
			if (REG_WE && REG_ADDR == psr_pkg::REG_CTRL)
				cfg_r <= REG_WDATA[psr_pkg::CB_CFG];
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// ==========
	// properties
	sequence s_cfg_on;
		$rose(cfg_r);
	endsequence
	sequence s_cfg_off;
		$fell(cfg_r) && cnt_r > POWERUP_CYCLES;
	endsequence
	property p_pwr_quiet;
		cnt_r < POWERUP_CYCLES - 1 |-> quiet;
	endproperty
	property p_pwr_reset;
		cnt_r < POWERUP_CYCLES - 2 |-> CONTROL_RESET;
	endproperty
	property p_cfg_enter;
		s_cfg_on |-> ##[0:2] CONTROL_RESET;
	endproperty
	property p_cfg_leave;
		s_cfg_off |-> ##[0:2] !CONTROL_RESET;
	endproperty
	property p_cfg_off;
		CONTROL_RESET && $past(CONTROL_RESET) |-> quiet;
	endproperty
	property p_end_stops;
		PROG_END && $past(PROG_END) && $past(PROG_END, 2)
			|-> $stable(PRESENT_TARGET_SETPOINT);
	endproperty
	property p_hold_freeze;
		EV_HOLD && $past(EV_HOLD, 3) && EV_RUN && $past(EV_RUN, 3)
			|-> $stable(PRESENT_TARGET_SETPOINT);
	endproperty
	property p_rdata_idle;
		!$past(REG_RE) |-> REG_RDATA == 16'h0000;
	endproperty
	a_pwr_quiet: assert property (p_pwr_quiet)
		else $error("output active during power-up");
	a_pwr_reset: assert property (p_pwr_reset)
		else $error("control reset low during power-up");
	a_cfg_enter: assert property (p_cfg_enter)
		else $error("config mode did not reset control");
	a_cfg_leave: assert property (p_cfg_leave)
		else $error("control reset kept after config");
	a_cfg_off: assert property (p_cfg_off)
		else $error("output active under control reset");
	a_end_stops: assert property (p_end_stops)
		else $error("setpoint moved after program end");
	a_hold_freeze: assert property (p_hold_freeze)
		else $error("setpoint moved during hold");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read cycle");
endmodule : psr_core_assertions

bind psr_core psr_core_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (
	.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
	.REG_RDATA(REG_RDATA), .EV_RUN(EV_RUN), .EV_HOLD(EV_HOLD),
	.CTRL_OUT1(CTRL_OUT1), .CTRL_OUT2(CTRL_OUT2), .AUX_OUT1(AUX_OUT1),
	.XFER_OUT(XFER_OUT), .PRESENT_TARGET_SETPOINT(PRESENT_TARGET_SETPOINT),
	.PROG_END(PROG_END), .CONTROL_RESET(CONTROL_RESET)
);

// ==== sim/psr_actuator_model.sv ====
// actuator model that notes when any routed output first energises
module psr_actuator_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic heat_on,
	input wire logic alarm_on,
	input wire logic aux_on,
	output int first_on
);
	timeunit 1ns;
	timeprecision 1ns;
	int cyc;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cyc <= 0;
			first_on <= -1;
		end else begin
			cyc <= cyc + 1;
			if ((heat_on || alarm_on || aux_on) && first_on < 0)
				first_on <= cyc;
		end
	end
endmodule : psr_actuator_model

// ==== sim/tb.sv ====
// self-checking bench for the program sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PWR = 20;
	logic ref_clk = 1'b0;
	logic rst, we, re, o1, o2, oa, pend, crst;
	logic ev_run, ev_hold, ev_adv, ev_pen;
	logic [1:0] ev_pat;
	logic [4:0] fin;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, pv, hmv, cmv, xout, sp, d;
	logic [15:0] srcv [4] = '{16'h0100, 16'h0600, 16'h2000, 16'h6000};
	logic [15:0] bad [4] = '{16'h0206, 16'h0280, 16'h0020, 16'h0920};
	logic [7:0] pa [12] = '{8'h50, 8'h51, 8'h90, 8'h91, 8'h02, 8'h03,
		8'h14, 8'h10, 8'h04, 8'h40, 8'h80, 8'hC0};
	logic [15:0] pd [12] = '{16'h0100, 16'h0200, 16'h0003, 16'h0002,
		16'h0010, 16'h0001, 16'h0500, 16'h7000, 16'h0801, 16'h0204,
		16'h0002, 16'h0001};
	int fail_count = 0;
	int n_tests = 0;
	int tcnt = 0;
	int first_on;
	always #25 ref_clk = ~ref_clk;
	psr_core #(.POWERUP_CYCLES(PWR), .TICK_CYCLES(4), .NPAT(4),
		.NSTEP(16)) dut (
		.REF_CLK(ref_clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
		.MEASURED_PROCESS_VALUE(pv), .HEAT_MV(hmv), .COOL_MV(cmv),
		.HEAT_CTRL(fin[0]), .COOL_CTRL(fin[1]),
		.CONTROL_LOOP_BREAK_ALARM(fin[2]), .INPUT_ERR(fin[3]),
		.ADC_ERR(fin[4]), .EV_RUN(ev_run), .EV_HOLD(ev_hold),
		.EV_ADVANCE(ev_adv), .EV_PATTERN_EN(ev_pen), .EV_PATTERN(ev_pat),
		.CTRL_OUT1(o1), .CTRL_OUT2(o2), .AUX_OUT1(oa), .XFER_OUT(xout),
		.PRESENT_TARGET_SETPOINT(sp), .PROG_END(pend),
		.CONTROL_RESET(crst)
	);
	psr_actuator_model u_act (
		.clk(ref_clk), .rst(rst), .heat_on(o1), .alarm_on(o2),
		.aux_on(oa), .first_on(first_on)
	);
	// ==========
	// bus and compare tasks
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chkb(input string n, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask : chkb
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : w
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		we <= 1'b1;
		@(posedge ref_clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		re <= 1'b1;
		@(posedge ref_clk);
		re <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask : rd
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e,
		input string n);
		rd(a);
		chk(n, e, d);
	endtask : rdchk
	task automatic rej(input logic e);
		rd(psr_pkg::REG_STATUS);
		chkb("reject", e, d[6]);
	endtask : rej
	function automatic logic [15:0] xf(input logic [15:0] lo, hi, s);
		int p;
		p = (int'($signed(hi)) - int'($signed(lo))) * int'($signed(s));
		return lo + 16'(p >>> 16);
	endfunction : xf
	// ==========
	// scenario helpers
	task automatic route(input logic [11:0] asg, input int b,
		input logic aux);
		wr(psr_pkg::REG_ASSIGN, {4'h0, asg});
		for (int v = 0; v < 2; v++) begin
			@(posedge ref_clk);
			fin <= v[0] ? 5'(1 << b) : 5'h00;
			w(3);
			chkb("routed", v[0], aux ? oa : o1);
		end
	endtask : route
	task automatic xfer(input logic [15:0] lo, input logic [15:0] hi);
		wr(psr_pkg::REG_XLO, lo);
		wr(psr_pkg::REG_XHI, hi);
		for (int s = 0; s < 4; s++) begin
			wr(psr_pkg::REG_CTRL, 16'(s << 10));
			w(3);
			chk("xfer_out", xf(lo, hi, srcv[s]), xout);
		end
	endtask : xfer
	task automatic wait_end;
		for (int i = 0; i < 80 && pend !== 1'b1; i++)
			@(negedge ref_clk);
		w(1);
	endtask : wait_end
	always @(posedge ref_clk) begin
		tcnt++;
		if (tcnt == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	// ==========
	// main sequence
	initial begin
		{we, re, ev_run, ev_hold, ev_adv, ev_pen} = '0;
		{addr, ev_pat, wdata} = '0;
		fin = 5'h01;
		pv = 16'h0600;
		hmv = 16'h2000;
		cmv = 16'h6000;
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		w(1);
		chkb("out1_inhibit", 1'b0, o1);
		chkb("control_reset", 1'b1, crst);
		rdchk(psr_pkg::REG_ASSIGN, 16'h0320, "assign_rst");
		rdchk(psr_pkg::REG_XHI, 16'hFFFF, "xhi_rst");
		rdchk(8'h0A, 16'h0000, "unmapped");
		w(PWR);
		chkb("out1_heat", 1'b1, o1);
		chkb("late_start", 1'b1, first_on >= PWR - 1);
		route(12'h200, 0, 1'b0);
		route(12'h205, 2, 1'b0);
		route(12'h520, 2, 1'b1);
		route(12'hA20, 3, 1'b1);
		route(12'hB20, 4, 1'b1);
		foreach (bad[i]) begin
			wr(psr_pkg::REG_ASSIGN, bad[i]);
			rdchk(psr_pkg::REG_ASSIGN, 16'h0B20, "assign_kept");
			rej(1'b1);
		end
		wr(psr_pkg::REG_CTRL, 16'h0200);
		rdchk(psr_pkg::REG_CTRL, 16'h0000, "ctrl_hcool");
		wr(psr_pkg::REG_ASSIGN, 16'h0210);
		rej(1'b0);
		wr(psr_pkg::REG_CTRL, 16'h0200);
		rdchk(psr_pkg::REG_CTRL, 16'h0200, "ctrl_hcool");
		wr(psr_pkg::REG_ASSIGN, 16'h0220);
		rdchk(psr_pkg::REG_ASSIGN, 16'h0210, "assign_cool");
		// cool control only reaches an output in heat/cool mode
		route(12'h201, 1, 1'b0);
		wr(psr_pkg::REG_CTRL, 16'h0000);
		wr(psr_pkg::REG_ASSIGN, 16'h0320);
		foreach (pa[i])
			wr(pa[i], pd[i]);
		@(posedge ref_clk);
		{ev_pen, ev_run, ev_pat} <= 4'b1101;
		w(3);
		chk("setpoint", 16'h0100, sp);
		chkb("alarm1", 1'b1, o2);
		@(posedge ref_clk);
		ev_hold <= 1'b1;
		w(24);
		chk("hold_sp", 16'h0100, sp);
		rd(psr_pkg::REG_STATUS);
		chk("status_hold", 16'h0103, d & 16'hF303);
		xfer(16'h1000, 16'h5000);
		xfer(16'h5000, 16'h1000);
		@(posedge ref_clk);
		pv <= 16'h0400;
		w(3);
		chkb("alarm1", 1'b0, o2);
		@(posedge ref_clk);
		{ev_hold, ev_adv} <= 2'b01;
		@(posedge ref_clk);
		ev_adv <= 1'b0;
		rd(psr_pkg::REG_STATUS);
		chk("status_adv", 16'h1111, d & 16'hF313);
		chk("adv_sp", 16'h0200, sp);
		wait_end();
		chkb("prog_end", 1'b1, pend);
		w(8);
		chk("end_sp", 16'h0200, sp);
		@(posedge ref_clk);
		ev_run <= 1'b0;
		w(3);
		chkb("idle_end", 1'b0, pend);
		wr(psr_pkg::REG_CTRL, 16'h0011);
		w(60);
		rd(psr_pkg::REG_STATUS);
		chk("repeat", 16'h0001, d & 16'h0005);
		wr(psr_pkg::REG_CTRL, 16'h0000);
		@(posedge ref_clk);
		ev_pen <= 1'b0;
		wr(psr_pkg::REG_CTRL, 16'h0021);
		wait_end();
		rd(psr_pkg::REG_STATUS);
		chk("run_all", 16'h0104, d & 16'h0304);
		// ramp method: setpoint walks from 0200 to 0204 at 2 per tick
		wr(psr_pkg::REG_CTRL, 16'h0000);
		@(posedge ref_clk);
		ev_hold <= 1'b1;
		wr(psr_pkg::REG_CTRL, 16'h0041);
		w(8);
		chk("ramp_hold", 16'h0200, sp);
		@(posedge ref_clk);
		ev_hold <= 1'b0;
		wait_end();
		chk("ramp_sp", 16'h0204, sp);
		chkb("ramp_end", 1'b1, pend);
		@(posedge ref_clk);
		fin <= 5'h01;
		wr(psr_pkg::REG_CTRL, 16'h0008);
		w(3);
		chkb("cfg_reset", 1'b1, crst);
		chkb("cfg_out1", 1'b0, o1);
		wr(psr_pkg::REG_CTRL, 16'h0000);
		w(3);
		chkb("cfg_out1", 1'b1, o1);
		report_and_stop();
	end
endmodule : tb
